// file: include/pnvm_map.vh
// constants of the parallel programming port
`ifndef PNVM_MAP_VH
`define PNVM_MAP_VH
`define PNVM_ACT_ADDR 2'h0
`define PNVM_ACT_DATA 2'h1
`define PNVM_ACT_CMD 2'h2
`define PNVM_ACT_IDLE 2'h3
`define PNVM_BS_LO 2'h0
`define PNVM_BS_HI 2'h1
`define PNVM_BS_EXT 2'h2
`define PNVM_BS_FHI 2'h3
`define PNVM_CMD_NOP 8'h00
`define PNVM_CMD_ERASE 8'h80
`define PNVM_CMD_WR_FUSE 8'h40
`define PNVM_CMD_WR_LOCK 8'h20
`define PNVM_CMD_WR_FLASH 8'h10
`define PNVM_CMD_WR_EE 8'h11
`define PNVM_CMD_RD_SIG 8'h08
`define PNVM_CMD_RD_FUSE 8'h04
`define PNVM_CMD_RD_FLASH 8'h02
`define PNVM_CMD_RD_EE 8'h03
`define PNVM_ERASED_BYTE 8'hFF
`define PNVM_ERASED_WORD 16'hFFFF
`define PNVM_BOOT_LOCK_MASK 8'h3C
`define PNVM_SIG_ADDR_MAX 8'h02
`define PNVM_PROG_CYCLES 64
`endif

// file: design/pnvm_buf.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pnvm_buf #(
  parameter W = 25
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output reg in_ready_r,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] ent_r [0:1];
  reg wr_ptr_r;
  reg rd_ptr_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;
  reg [1:0] cnt_nxt;

  assign out_valid = (cnt_r != 2'h0);
  assign out_data = ent_r[rd_ptr_r];
  assign push = in_valid & in_ready_r;
  assign pop = out_valid & out_ready;

  always @*
  begin
    cnt_nxt = cnt_r;
    if (push & ~pop)
      cnt_nxt = cnt_r + 2'h1;
    else if (pop & ~push)
      cnt_nxt = cnt_r - 2'h1;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
      in_ready_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt != 2'h2);
      if (push)
      begin
        ent_r[wr_ptr_r] <= in_data;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
    end
  end
endmodule // pnvm_buf

// file: design/pnvm_timer.v
// self-timed write delay counter
`timescale 1ns/1ps
module pnvm_timer #(
  parameter CYC = 64
) (
  input wire clk,
  input wire rst,
  input wire start,
  output reg done_r
);
  reg [15:0] cnt_r;

  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= 16'h0000;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= (cnt_r == 16'h0001);
      if (start)
        cnt_r <= CYC[15:0];
      else if (cnt_r != 16'h0000)
        cnt_r <= cnt_r - 16'h0001;
    end
  end
endmodule // pnvm_timer

// file: design/pnvm_top.v
// parallel programming port for flash, eeprom, fuses, lock and signature
// Functional notes
// RULE1: address action with byte select 01 stores address bits 15..8.
// RULE2: address action with byte select 10 stores address bits 23..16.
// RULE3: write strobe low with select 00 programs flash page; ready low meanwhile.
// RULE4: programmer repeats address, data, latch and page write per page.
// RULE5: command 00 is a no-operation that resets internal write state.
// RULE6: command 11 writes eeprom; high address once, then latch bytes.
// RULE7: write strobe with select 00 programs eeprom page; ready low meanwhile.
// RULE8: flash read drives low byte at select-low 0, high byte at 1.
// RULE9: eeprom read drives the addressed byte while output enable low.
// RULE10: fuse command 40, write strobe writes fuse low byte; 0 programs.
// RULE11: byte select 01 with write strobe writes the fuse high byte.
// RULE12: byte select 10 with write strobe writes the extended fuse byte.
// RULE13: lock command 20; write strobe programs zero bits of the lock byte.
// RULE14: both main lock bits programmed blocks programming of boot lock bits.
// RULE15: lock bits clear only through chip erase; the code also loads FF into lock_r on RST.
// RULE16: fuse read: 00 low, 11 high, 10 extended, 01 lock byte.
// RULE17: signature command with low address up to 02 drives signature byte.
// RULE18: signature command, address 00, select-low 1 drives calibration byte.
// RULE19: in serial mode no program or erase before enable is accepted.
// RULE20: action lines pick address, data, command or nothing for a load.
// RULE21: data bus driven only while output enable is low.
// RULE22: command and address stay until reloaded.
// RULE23: page latch with select-low 1 copies data word into page buffer.
// RULE24: ready stays high when no write is in progress.
`timescale 1ns/1ps
`include "pnvm_map.vh"
module pnvm_top #(
  parameter FAW = 12,
  parameter FPW = 6,
  parameter EAW = 9,
  parameter EPW = 2,
  parameter PROG_CYCLES = `PNVM_PROG_CYCLES,
  parameter [7:0] SIG0 = 8'h5A, // arbitrary value
  parameter [7:0] SIG1 = 8'hA5, // arbitrary value
  parameter [7:0] SIG2 = 8'h3C, // arbitrary value
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input wire SYS_CLK,
  input wire RST,
  input wire LOAD_CLOCK,
  input wire ACTION_SEL_HI,
  input wire ACTION_SEL_LO,
  input wire BYTE_SEL_HI,
  input wire BYTE_SEL_LO,
  input wire PAGE_LATCH_STROBE,
  input wire WR_N,
  input wire OE_N,
  input wire [7:0] DATA_IN,
  output reg [7:0] DATA_OUT,
  output reg DATA_OE,
  output reg READY_BUSY_N,
  output wire LATCH_READY,
  input wire SER_MODE,
  input wire SER_ENABLE_ACK
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PEND = 3'h1;
  localparam ST_COPY = 3'h2;
  localparam ST_ERASE = 3'h3;
  localparam ST_TIME = 3'h4;
  localparam BW = 25;
  localparam XAW = (FAW > EAW) ? FAW : EAW;

  reg [15:0] flash_mem [0:(1<<FAW)-1];
  reg [7:0] ee_mem [0:(1<<EAW)-1];
  reg [15:0] fl_pbuf [0:(1<<FPW)-1];
  reg [7:0] ee_pbuf [0:(1<<EPW)-1];
  reg [7:0] cmd_r;
  reg [7:0] addr_lo_r;
  reg [7:0] addr_hi_r;
  reg [7:0] addr_ext_r;
  reg [7:0] dat_lo_r;
  reg [7:0] dat_hi_r;
  reg [7:0] fuse_lo_r;
  reg [7:0] fuse_hi_r;
  reg [7:0] fuse_ext_r;
  reg [7:0] lock_r;
  reg load_q_r;
  reg wr_q_r;
  reg latch_q_r;
  reg ser_en_r;
  reg dirty_r;
  reg is_ee_r;
  reg [2:0] st_r;
  reg [XAW-1:0] idx_r;
  reg tstart_r;
  reg [7:0] rd_nxt;
  wire load_rise;
  wire wr_fall;
  wire latch_rise;
  wire [1:0] act;
  wire [1:0] bsel;
  wire [23:0] full_addr;
  wire [FAW-1:0] faddr;
  wire [EAW-1:0] eaddr;
  wire [FAW-1:0] fl_dst;
  wire [EAW-1:0] ee_dst;
  wire wr_allowed;
  wire main_lock3;
  wire buf_valid;
  wire buf_ready;
  wire [BW-1:0] buf_data;
  wire tdone;
  wire [15:0] flash_word;

  assign act = {ACTION_SEL_HI, ACTION_SEL_LO};
  assign bsel = {BYTE_SEL_HI, BYTE_SEL_LO};
  assign load_rise = LOAD_CLOCK & ~load_q_r;
  assign wr_fall = ~WR_N & wr_q_r;
  assign latch_rise = PAGE_LATCH_STROBE & ~latch_q_r;
  assign full_addr = {addr_ext_r, addr_hi_r, addr_lo_r};
  assign faddr = full_addr[FAW-1:0];
  assign eaddr = full_addr[EAW-1:0];
  assign flash_word = flash_mem[faddr];
  assign fl_dst = {faddr[FAW-1:FPW], idx_r[FPW-1:0]};
  assign ee_dst = {eaddr[EAW-1:EPW], idx_r[EPW-1:0]};
  assign wr_allowed = ~SER_MODE | ser_en_r; // see RULE19
  assign main_lock3 = ~lock_r[0] & ~lock_r[1]; // see RULE14
  // drain stalls while the page is being committed
  assign buf_ready = (st_r == ST_IDLE);

  pnvm_buf #(
    .W(BW)
  ) u_buf (
    .clk(SYS_CLK),
    .rst(RST),
    .in_valid(latch_rise & BYTE_SEL_LO),
    .in_ready_r(LATCH_READY),
    .in_data({cmd_r == `PNVM_CMD_WR_EE, addr_lo_r, dat_hi_r, dat_lo_r}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  pnvm_timer #(
    .CYC(PROG_CYCLES)
  ) u_timer (
    .clk(SYS_CLK),
    .rst(RST),
    .start(tstart_r),
    .done_r(tdone)
  );

  // read data selection
  always @*
  begin
    rd_nxt = `PNVM_ERASED_BYTE;
    case (cmd_r)
      `PNVM_CMD_RD_FLASH:
        rd_nxt = BYTE_SEL_LO ? flash_word[15:8] : flash_word[7:0]; // see RULE8
      `PNVM_CMD_RD_EE:
        rd_nxt = ee_mem[eaddr]; // see RULE9
      `PNVM_CMD_RD_FUSE:
        case (bsel) // see RULE16
          `PNVM_BS_LO: rd_nxt = fuse_lo_r;
          `PNVM_BS_FHI: rd_nxt = fuse_hi_r;
          `PNVM_BS_EXT: rd_nxt = fuse_ext_r;
          default: rd_nxt = lock_r;
        endcase
      `PNVM_CMD_RD_SIG:
        if (BYTE_SEL_LO)
          rd_nxt = (addr_lo_r == 8'h00) ? CAL_BYTE : `PNVM_ERASED_BYTE; // see RULE18
        else if (addr_lo_r == 8'h00)
          rd_nxt = SIG0; // see RULE17
        else if (addr_lo_r == 8'h01)
          rd_nxt = SIG1;
        else if (addr_lo_r == `PNVM_SIG_ADDR_MAX)
          rd_nxt = SIG2;
        else
          rd_nxt = `PNVM_ERASED_BYTE;
      default:
        rd_nxt = `PNVM_ERASED_BYTE;
    endcase
  end

  // bus drive and strobe history
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
      load_q_r <= 1'b0;
      wr_q_r <= 1'b1;
      latch_q_r <= 1'b0;
      ser_en_r <= 1'b0;
    end
    else
    begin
      DATA_OE <= ~OE_N; // see RULE21
      DATA_OUT <= OE_N ? 8'h00 : rd_nxt;
      load_q_r <= LOAD_CLOCK;
      wr_q_r <= WR_N;
      latch_q_r <= PAGE_LATCH_STROBE;
      if (~SER_MODE)
        ser_en_r <= 1'b0;
      else if (SER_ENABLE_ACK)
        ser_en_r <= 1'b1; // see RULE19
    end
  end

  // command, address and data loading
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      cmd_r <= `PNVM_CMD_NOP;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      addr_ext_r <= 8'h00;
      dat_lo_r <= 8'h00;
      dat_hi_r <= 8'h00;
    end
    else if (load_rise) // see RULE22
    begin
      case (act) // see RULE20
        `PNVM_ACT_ADDR:
          case (bsel)
            `PNVM_BS_LO: addr_lo_r <= DATA_IN;
            `PNVM_BS_HI: addr_hi_r <= DATA_IN; // see RULE1
            `PNVM_BS_EXT: addr_ext_r <= DATA_IN; // see RULE2
            default: addr_lo_r <= addr_lo_r;
          endcase
        `PNVM_ACT_DATA:
          if (BYTE_SEL_LO)
            dat_hi_r <= DATA_IN;
          else
            dat_lo_r <= DATA_IN;
        `PNVM_ACT_CMD:
          cmd_r <= DATA_IN;
        default:
          cmd_r <= cmd_r;
      endcase
    end
  end

  // page buffers, write engine and nonvolatile state
  always @(posedge SYS_CLK)
  begin
    if (buf_valid & buf_ready)
    begin
      if (buf_data[24])
        ee_pbuf[buf_data[16+EPW-1:16]] <= buf_data[7:0]; // see RULE6
      else
        fl_pbuf[buf_data[16+FPW-1:16]] <= buf_data[15:0]; // see RULE23
    end
    if (st_r == ST_COPY)
    begin
      if (is_ee_r)
        ee_mem[ee_dst] <= ee_pbuf[idx_r[EPW-1:0]]; // see RULE7
      else
        flash_mem[fl_dst] <= fl_pbuf[idx_r[FPW-1:0]]; // see RULE3
    end
    if (st_r == ST_ERASE)
    begin
      flash_mem[idx_r[FAW-1:0]] <= `PNVM_ERASED_WORD;
      ee_mem[idx_r[EAW-1:0]] <= `PNVM_ERASED_BYTE;
    end
  end

  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      st_r <= ST_IDLE;
      idx_r <= {XAW{1'b0}};
      is_ee_r <= 1'b0;
      dirty_r <= 1'b0;
      tstart_r <= 1'b0;
      READY_BUSY_N <= 1'b1;
      fuse_lo_r <= `PNVM_ERASED_BYTE;
      fuse_hi_r <= `PNVM_ERASED_BYTE;
      fuse_ext_r <= `PNVM_ERASED_BYTE;
      lock_r <= `PNVM_ERASED_BYTE;
    end
    else
    begin
      tstart_r <= 1'b0;
      if (buf_valid & buf_ready)
        dirty_r <= 1'b1;
      else if (load_rise && act == `PNVM_ACT_CMD && DATA_IN == `PNVM_CMD_NOP)
        dirty_r <= 1'b0; // see RULE5
      case (st_r)
        ST_IDLE:
        begin
          READY_BUSY_N <= 1'b1; // see RULE24
          if (wr_fall & wr_allowed)
          begin
            case (cmd_r)
              `PNVM_CMD_WR_FLASH, `PNVM_CMD_WR_EE:
                if (bsel == `PNVM_BS_LO && dirty_r)
                begin
                  is_ee_r <= (cmd_r == `PNVM_CMD_WR_EE);
                  st_r <= ST_PEND;
                  READY_BUSY_N <= 1'b0; // see RULE3
                end
              `PNVM_CMD_ERASE:
              begin
                st_r <= ST_ERASE;
                READY_BUSY_N <= 1'b0;
              end
              `PNVM_CMD_WR_FUSE:
              begin
                case (bsel)
                  `PNVM_BS_LO: fuse_lo_r <= dat_lo_r; // see RULE10
                  `PNVM_BS_HI: fuse_hi_r <= dat_lo_r; // see RULE11
                  `PNVM_BS_EXT: fuse_ext_r <= dat_lo_r; // see RULE12
                  default: fuse_lo_r <= fuse_lo_r;
                endcase
                tstart_r <= 1'b1;
                st_r <= ST_TIME;
                READY_BUSY_N <= 1'b0;
              end
              `PNVM_CMD_WR_LOCK:
              begin
                // bits can only go to zero here; see RULE13 see RULE15
                if (main_lock3)
                  lock_r <= lock_r & (dat_lo_r | `PNVM_BOOT_LOCK_MASK); // see RULE14
                else
                  lock_r <= lock_r & dat_lo_r;
                tstart_r <= 1'b1;
                st_r <= ST_TIME;
                READY_BUSY_N <= 1'b0;
              end
              default:
                st_r <= ST_IDLE;
            endcase
          end
        end
        ST_PEND:
          if (~buf_valid)
          begin
            idx_r <= {XAW{1'b0}};
            st_r <= ST_COPY;
          end
        ST_COPY:
          if ((is_ee_r && idx_r == (1 << EPW) - 1) ||
              (~is_ee_r && idx_r == (1 << FPW) - 1))
          begin
            idx_r <= {XAW{1'b0}};
            dirty_r <= 1'b0;
            tstart_r <= 1'b1;
            st_r <= ST_TIME;
          end
          else
            idx_r <= idx_r + {{(XAW-1){1'b0}}, 1'b1};
        ST_ERASE:
          if (idx_r == {XAW{1'b1}})
          begin
            idx_r <= {XAW{1'b0}};
            lock_r <= `PNVM_ERASED_BYTE; // see RULE15
            tstart_r <= 1'b1;
            st_r <= ST_TIME;
          end
          else
            idx_r <= idx_r + {{(XAW-1){1'b0}}, 1'b1};
        ST_TIME:
          if (tdone)
          begin
            READY_BUSY_N <= 1'b1;
            st_r <= ST_IDLE;
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end
endmodule // pnvm_top

// file: sim/pnvm_top_asserts.sv
// concurrent checks on the programming port
`timescale 1ns/1ps
module pnvm_chk (
  input wire SYS_CLK,
  input wire RST,
  input wire LOAD_CLOCK,
  input wire ACTION_SEL_HI,
  input wire ACTION_SEL_LO,
  input wire BYTE_SEL_HI,
  input wire BYTE_SEL_LO,
  input wire PAGE_LATCH_STROBE,
  input wire WR_N,
  input wire OE_N,
  input wire [7:0] DATA_IN,
  input wire [7:0] DATA_OUT,
  input wire DATA_OE,
  input wire READY_BUSY_N,
  input wire LATCH_READY,
  input wire SER_MODE,
  input wire SER_ENABLE_ACK
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  a_oe_drive: assert property (!OE_N |=> DATA_OE)
    else $error("bus not driven on read");
  a_oe_only: assert property (DATA_OE |-> !$past(OE_N))
    else $error("bus driven without read");
  a_out_quiet: assert property (!DATA_OE |-> DATA_OUT == 8'h00)
    else $error("read data while released");
  a_busy_cause: assert property ($fell(READY_BUSY_N) |-> (!$past(WR_N) || !$past(WR_N, 2)))
    else $error("busy without write strobe");
  a_busy_hold: assert property ($fell(READY_BUSY_N) |-> !READY_BUSY_N [*4])
    else $error("busy too short");
  a_busy_ends: assert property ($fell(READY_BUSY_N) |-> ##[1:700] READY_BUSY_N)
    else $error("busy never ends");
  a_ready_idle: assert property (READY_BUSY_N && WR_N && $past(WR_N) |=> READY_BUSY_N)
    else $error("busy while idle");
  a_latch_drain: assert property ($fell(LATCH_READY) |-> ##[1:700] LATCH_READY)
    else $error("latch buffer stuck");
  a_reset_idle: assert property (disable iff (1'b0) RST |=> READY_BUSY_N && LATCH_READY && !DATA_OE)
    else $error("not idle after reset");
  c_write: cover property ($fell(READY_BUSY_N));
  c_read: cover property (DATA_OE && !OE_N);
  c_full: cover property ($fell(LATCH_READY));
endmodule // pnvm_chk
bind pnvm_top pnvm_chk u_chk (
  .SYS_CLK(SYS_CLK),
  .RST(RST),
  .LOAD_CLOCK(LOAD_CLOCK),
  .ACTION_SEL_HI(ACTION_SEL_HI),
  .ACTION_SEL_LO(ACTION_SEL_LO),
  .BYTE_SEL_HI(BYTE_SEL_HI),
  .BYTE_SEL_LO(BYTE_SEL_LO),
  .PAGE_LATCH_STROBE(PAGE_LATCH_STROBE),
  .WR_N(WR_N),
  .OE_N(OE_N),
  .DATA_IN(DATA_IN),
  .DATA_OUT(DATA_OUT),
  .DATA_OE(DATA_OE),
  .READY_BUSY_N(READY_BUSY_N),
  .LATCH_READY(LATCH_READY),
  .SER_MODE(SER_MODE),
  .SER_ENABLE_ACK(SER_ENABLE_ACK)
);

// file: sim/pnvm_prog_model.sv
// external programmer model driving load, latch and write strobes
`timescale 1ns/1ps
module pnvm_prog (
  input wire clk,
  input wire [7:0] dout,
  input wire doe,
  input wire rdy,
  output reg lc,
  output reg xh,
  output reg xl,
  output reg bh,
  output reg bl,
  output reg pl,
  output reg wn,
  output reg oen,
  output wire [7:0] din
);
  reg [7:0] pd;
  integer k;
  integer n_late = 0;
  // shared data wire
  assign din = doe ? dout : pd;
  initial
  begin
    {lc, xh, xl, bh, bl, pl, wn, oen} = 8'h63;
    pd = 8'h00;
  end
  task ld(input [1:0] a, input [1:0] b, input [7:0] d);
    @(posedge clk);
    {xh, xl} <= a;
    {bh, bl} <= b;
    pd <= d;
    @(posedge clk);
    lc <= 1'b1;
    @(posedge clk);
    lc <= 1'b0;
  endtask
  task lat;
    @(posedge clk);
    bl <= 1'b1;
    pl <= 1'b1;
    @(posedge clk);
    pl <= 1'b0;
  endtask
  task ws(input [1:0] b, output bsy);
    @(posedge clk);
    {bh, bl} <= b;
    wn <= 1'b0;
    @(posedge clk);
    wn <= 1'b1;
    @(posedge clk);
    #1 bsy = !rdy;
  endtask
  task ww;
    k = 0;
    while (rdy !== 1'b1 && k < 2000)
    begin
      @(posedge clk);
      #1 k = k + 1;
    end
    // busy that never ends counts against the run
    if (rdy !== 1'b1)
      n_late = n_late + 1;
  endtask
  task rd(input [1:0] b, output [7:0] d);
    @(posedge clk);
    {bh, bl} <= b;
    oen <= 1'b0;
    pd <= ~pd;
    @(posedge clk);
    #1 d = din;
    @(posedge clk);
    oen <= 1'b1;
  endtask
endmodule // pnvm_prog

// file: sim/tb_top.sv
// self-checking bench for the programming port
`timescale 1ns/1ps
module tb_top;
  localparam [23:0] SIGS = 24'h96C3E7; // arbitrary values
  localparam [7:0] CAL = 8'h4E;
  localparam [23:0] FV = 24'hBFD0E1;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg ser_mode = 1'b0;
  reg ser_ack = 1'b0;
  wire [7:0] dout;
  wire [7:0] din;
  wire doe, rdy, lrdy, lc, xh, xl, bh, bl, pl, wn, oen;
  integer n_errors = 0;
  integer num_checks = 0;
  integer i;
  reg [7:0] d;
  reg b;
  always #25 sys_clk = ~sys_clk;
  pnvm_top #(.FAW(9), .FPW(3), .EAW(5), .EPW(1), .SIG0(SIGS[7:0]), .SIG1(SIGS[15:8]),
    .SIG2(SIGS[23:16]), .CAL_BYTE(CAL)) uut (
    .SYS_CLK(sys_clk),
    .RST(rst),
    .LOAD_CLOCK(lc),
    .ACTION_SEL_HI(xh),
    .ACTION_SEL_LO(xl),
    .BYTE_SEL_HI(bh),
    .BYTE_SEL_LO(bl),
    .PAGE_LATCH_STROBE(pl),
    .WR_N(wn),
    .OE_N(oen),
    .DATA_IN(din),
    .DATA_OUT(dout),
    .DATA_OE(doe),
    .READY_BUSY_N(rdy),
    .LATCH_READY(lrdy),
    .SER_MODE(ser_mode),
    .SER_ENABLE_ACK(ser_ack)
  );
  pnvm_prog p (.clk(sys_clk), .dout(dout), .doe(doe), .rdy(rdy), .lc(lc), .xh(xh), .xl(xl),
    .bh(bh), .bl(bl), .pl(pl), .wn(wn), .oen(oen), .din(din));
  task chk(input [7:0] s, input [7:0] e);
    num_checks = num_checks + 1;
    if (s !== e)
    begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task print_verdict;
    n_errors = n_errors + p.n_late;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cmd(input [7:0] c);
    p.ld(2'h2, 2'h0, c);
  endtask
  task ad(input [1:0] s, input [7:0] v);
    p.ld(2'h0, s, v);
  endtask
  task dt(input hi, input [7:0] v);
    p.ld(2'h1, {1'b0, hi}, v);
  endtask
  task rc(input [1:0] s, input [7:0] e);
    p.rd(s, d);
    chk(d, e);
  endtask
  task wp(input e);
    p.ws(2'h0, b);
    chk({7'h00, b}, {7'h00, e});
    p.ww;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    print_verdict;
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 chk({6'h00, rdy, lrdy}, 8'h03);
    cmd(8'h80);
    wp(1'b1);
    cmd(8'h40);
    for (i = 0; i < 3; i = i + 1)
    begin
      dt(1'b0, FV[8*i +: 8]);
      p.ws(i[1:0], b);
      chk({7'h00, b}, 8'h01);
      p.ww;
    end
    p.ws(2'h3, b);
    chk({7'h00, b}, 8'h01);
    p.ww;
    cmd(8'h04);
    rc(2'h0, FV[7:0]);
    rc(2'h3, FV[15:8]);
    rc(2'h2, FV[23:16]);
    rc(2'h1, 8'hFF);
    cmd(8'h20);
    dt(1'b0, 8'hFC);
    wp(1'b1);
    dt(1'b0, 8'hC3);
    p.ws(2'h0, b);
    p.ww;
    dt(1'b0, 8'hFF);
    p.ws(2'h0, b);
    p.ww;
    cmd(8'h04);
    rc(2'h1, 8'hFC);
    p.ld(2'h3, 2'h0, 8'h02);
    rc(2'h1, 8'hFC);
    cmd(8'h80);
    wp(1'b1);
    cmd(8'h04);
    rc(2'h1, 8'hFF);
    rc(2'h0, FV[7:0]);
    cmd(8'h10);
    ad(2'h2, 8'h00);
    ad(2'h1, 8'h00);
    for (i = 0; i < 5; i = i + 1)
    begin
      if (i == 2)
      begin
        p.ws(2'h0, b);
        chk({7'h00, b}, 8'h01);
      end
      ad(2'h0, {7'h00, i[0]});
      dt(1'b0, 8'hA0 + i[7:0]);
      dt(1'b1, 8'h50 + i[7:0]);
      p.lat;
    end
    #1 chk({7'h00, lrdy}, 8'h00);
    p.ww;
    ad(2'h1, 8'h01);
    wp(1'b1);
    p.lat;
    cmd(8'h00);
    cmd(8'h10);
    p.ws(2'h0, b);
    chk({7'h00, b}, 8'h00);
    cmd(8'h02);
    ad(2'h2, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      ad(2'h1, {7'h00, i[1]});
      ad(2'h0, {7'h00, i[0]});
      rc(2'h0, 8'hA0 + i[7:0]);
      rc(2'h1, 8'h50 + i[7:0]);
    end
    cmd(8'h11);
    ad(2'h1, 8'h00);
    for (i = 0; i < 2; i = i + 1)
    begin
      ad(2'h0, i[7:0]);
      dt(1'b0, 8'h30 + i[7:0]);
      p.lat;
    end
    wp(1'b1);
    cmd(8'h03);
    for (i = 0; i < 2; i = i + 1)
    begin
      ad(2'h0, i[7:0]);
      rc(2'h0, 8'h30 + i[7:0]);
    end
    cmd(8'h08);
    for (i = 0; i < 3; i = i + 1)
    begin
      ad(2'h0, i[7:0]);
      rc(2'h0, SIGS[8*i +: 8]);
    end
    ad(2'h0, 8'h00);
    rc(2'h1, CAL);
    @(posedge sys_clk);
    ser_mode <= 1'b1;
    cmd(8'h40);
    p.ws(2'h0, b);
    chk({7'h00, b}, 8'h00);
    @(posedge sys_clk);
    ser_ack <= 1'b1;
    @(posedge sys_clk);
    ser_ack <= 1'b0;
    wp(1'b1);
    print_verdict;
  end
endmodule // tb_top
